// File: shared/act_pkg.sv
// Purpose: constants for the network-side activation state machine
// Assumes: 250 MHz clock, 4-bit command/indication channel
// Notes: codes shared by line-termination and network-termination modes
package act_pkg;
   // =====================================================
   // timing
   localparam int CLK_KHZ = 250000;
   localparam int AWAKE_MS = 4;
   localparam int INFO0_MS = 16;
   localparam int DEACT_MS = 32;
   localparam int ACT_US = 1990;
   localparam int CONT_KHZ = 96;
   localparam int SINGLE_KHZ = 2;
   localparam int AWAKE_CYC = AWAKE_MS * CLK_KHZ;
   localparam int INFO0_CYC = INFO0_MS * CLK_KHZ;
   localparam int DEACT_CYC = DEACT_MS * CLK_KHZ;
   localparam int ACT_CYC = (ACT_US * CLK_KHZ) / 1000;
   localparam int CONT_CYC = CLK_KHZ / CONT_KHZ;
   localparam int SINGLE_CYC = CLK_KHZ / SINGLE_KHZ;
   // =====================================================
   // downstream commands
   localparam logic [3:0] DEACTIVATE_REQUEST_CMD = 4'h0;
   localparam logic [3:0] CONTINUOUS_PULSE_CMD = 4'h1;
   localparam logic [3:0] SINGLE_PULSE_CMD = 4'h2;
   localparam logic [3:0] RESYNC_DOWN_CMD = 4'h4;
   localparam logic [3:0] ACTIVATE_REQUEST_DOWN_CMD = 4'h8;
   localparam logic [3:0] LOOP_ACTIVATE_REQUEST_CMD = 4'hA;
   localparam logic [3:0] SWITCH_THROUGH_CMD = 4'hC;
   localparam logic [3:0] SWITCH_THROUGH_LOOP_CMD = 4'hE;
   localparam logic [3:0] DEACTIVATION_ACK_CMD = 4'hF;
   // =====================================================
   // upstream indications
   localparam logic [3:0] CLOCKS_REQUIRED_IND = 4'h0;
   localparam logic [3:0] SIGNAL_LOST_IND = 4'h1;
   localparam logic [3:0] UPSTREAM_UNSYNC_IND = 4'h4;
   localparam logic [3:0] ERROR_IND = 4'h6;
   localparam logic [3:0] ACTIVATE_REQUEST_UP_IND = 4'h8;
   localparam logic [3:0] ACTIVATED_UP_IND = 4'hC;
   localparam logic [3:0] DEACTIVATED_UP_IND = 4'hF;
   // =====================================================
   // line signal selection
   typedef enum logic [2:0] {
      TX_INFO0 = 3'h0,
      TX_INFO2 = 3'h1,
      TX_INFO4 = 3'h2,
      TX_CONT = 3'h3,
      TX_SINGLE = 3'h4
   } tx_sel_t;
   // alternating pulse polarity codes on tx_pulse
   localparam logic [1:0] PULSE_NONE = 2'h0;
   localparam logic [1:0] PULSE_POS = 2'h1;
   localparam logic [1:0] PULSE_NEG = 2'h2;
endpackage : act_pkg

// File: rtl/network_side_activation_fsm.sv
// Purpose: layer-1 activation/deactivation for the network side of an S/T transceiver
// Assumes: receiver status flags are synchronous to clk; commands arrive once per frame
// Notes:
`timescale 1ns/1ps
module network_side_activation_fsm #(
   parameter int AWAKE_CYC = act_pkg::AWAKE_CYC,
   parameter int INFO0_CYC = act_pkg::INFO0_CYC,
   parameter int DEACT_CYC = act_pkg::DEACT_CYC,
   parameter int ACT_CYC = act_pkg::ACT_CYC,
   parameter int SINGLE_CYC = act_pkg::SINGLE_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic nt_mode,
   input wire logic frame_strobe,
   input wire logic [3:0] cmd_code,
   input wire logic rx_signal,
   input wire logic rx_info0,
   input wire logic rx_info1,
   input wire logic rx_info3,
   input wire logic rx_sync,
   output logic [3:0] ind_code,
   output act_pkg::tx_sel_t tx_sel,
   output logic [1:0] tx_pulse,
   output logic loop2_closed,
   output logic transparent
);
   // =====================================================
   // states
   typedef enum logic [10:0] {
      S_RESET = 11'h001,
      S_DEACT = 11'h002,
      S_INFO1 = 11'h004,
      S_AWAKE = 11'h008,
      S_PEND_ACT = 11'h010,
      S_SYNC = 11'h020,
      S_ACTIVE = 11'h040,
      S_PEND_DEACT = 11'h080,
      S_UNACK = 11'h100,
      S_TEST = 11'h200,
      S_RESYNC = 11'h400
   } state_t;

   // 24 bits hold the 32 ms count at 250 MHz; a clock above 524 MHz needs a wider timer
   localparam int TW = 24;

   state_t state_reg, state_next;
   logic [3:0] cmd_prev_reg;
   logic [3:0] cmd_reg;
   logic cmd_valid_reg;
   logic [TW-1:0] timer_reg, timer_next;
   logic [TW-1:0] info0_cnt_reg;
   logic [TW-1:0] pulse_cnt_reg;
   logic single_reg;
   logic loop_reg, loop_next;
   logic pol_reg;
   logic [3:0] ind_reg, ind_next;
   logic [2:0] sel_reg, sel_next;
   logic trans_reg, trans_next;

   // =====================================================
   // command filter: a new code counts once it repeats in the next frame
   wire cmd_same = frame_strobe && (cmd_code == cmd_prev_reg);
   wire cmd_new = cmd_same && (!cmd_valid_reg || cmd_code != cmd_reg);
   wire is_dr = cmd_new && cmd_code == act_pkg::DEACTIVATE_REQUEST_CMD;
   wire is_cont = cmd_new && !nt_mode && cmd_code == act_pkg::CONTINUOUS_PULSE_CMD;
   wire is_single = cmd_new && cmd_code == act_pkg::SINGLE_PULSE_CMD;
   wire is_resync = cmd_new && nt_mode && cmd_code == act_pkg::RESYNC_DOWN_CMD;
   wire is_ard = cmd_new && cmd_code == act_pkg::ACTIVATE_REQUEST_DOWN_CMD;
   wire is_arl = cmd_new && cmd_code == act_pkg::LOOP_ACTIVATE_REQUEST_CMD;
   wire is_aid = cmd_new && nt_mode && cmd_code == act_pkg::SWITCH_THROUGH_CMD;
   wire is_ail = cmd_new && nt_mode && cmd_code == act_pkg::SWITCH_THROUGH_LOOP_CMD;
   wire is_ack = cmd_new && cmd_code == act_pkg::DEACTIVATION_ACK_CMD;
   // the pattern follows the command itself, so single pulses never start at the fast rate
   wire single_sel = is_single || (single_reg && !is_cont);

   wire [TW-1:0] info0_lim = TW'(INFO0_CYC);
   wire info0_done = info0_cnt_reg >= info0_lim;
   // one down counter serves both the awake wait and the deactivation timeout
   wire timer_zero = timer_reg == '0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // both start at the acknowledge code, so the first frame after reset already counts
         cmd_prev_reg <= 4'hF;
         cmd_reg <= 4'hF;
         cmd_valid_reg <= 1'b0;
      end else if (frame_strobe) begin
         cmd_prev_reg <= cmd_code;
         if (cmd_same) begin
            cmd_reg <= cmd_code;
            cmd_valid_reg <= 1'b1;
         end
      end
   end

   // =====================================================
   // next state
   always_comb begin
      state_next = state_reg;
      timer_next = timer_zero ? '0 : timer_reg - 1'b1;
      loop_next = loop_reg;
      if (is_cont) begin
         state_next = S_TEST;
         loop_next = 1'b0;
      end else if (is_single) begin
         state_next = S_TEST;
         loop_next = 1'b0;
      end else if (is_resync) begin
         state_next = S_RESYNC;
         // loop 2 opens here so a later acknowledge never leaves it closed while idle
         loop_next = 1'b0;
      end else if (is_dr && state_reg != S_UNACK && state_reg != S_PEND_DEACT) begin
         state_next = S_PEND_DEACT;
         timer_next = TW'(DEACT_CYC);
         loop_next = 1'b0;
      end else begin
         case (state_reg)
            S_RESET: begin
               if (is_ack) state_next = S_DEACT;
            end
            S_DEACT: begin
               // lt mode stays silent here until line or command wakes it
               // network side: a command sends info2 at once, a line wake-up shows clocks-required
               if (is_ard || is_arl) begin
                  state_next = nt_mode ? S_PEND_ACT : S_AWAKE;
                  timer_next = TW'(AWAKE_CYC);
                  loop_next = is_arl;
               end else if (rx_info1) begin
                  state_next = S_AWAKE;
                  timer_next = TW'(AWAKE_CYC);
               end
            end
            S_INFO1: begin
               if (is_ard || is_arl) begin
                  state_next = S_PEND_ACT;
                  loop_next = is_arl;
               end
            end
            S_AWAKE: begin
               // info3 supervision is left to the controller
               // network side then waits in the info1 state for the downstream activate command
               if (timer_zero) state_next = nt_mode ? S_INFO1 : S_PEND_ACT;
            end
            S_PEND_ACT: begin
               if (rx_info3) begin
                  state_next = nt_mode ? S_SYNC : S_ACTIVE;
                  timer_next = TW'(ACT_CYC);
               end
            end
            S_SYNC: begin
               if (is_aid || is_ail) begin
                  state_next = S_ACTIVE;
                  loop_next = is_ail;
               end
            end
            S_ACTIVE: begin
               if (!rx_sync) state_next = S_PEND_ACT;
            end
            S_PEND_DEACT: begin
               if (info0_done || timer_zero) state_next = S_UNACK;
            end
            S_UNACK: begin
               if (is_ack) state_next = S_DEACT;
            end
            S_TEST, S_RESYNC: begin
               if (is_ack) state_next = S_DEACT;
               else if (is_ard || is_arl) begin
                  state_next = S_PEND_ACT;
                  loop_next = is_arl;
               end
            end
            default: state_next = S_RESET;
         endcase
      end
   end

   // =====================================================
   // outputs
   always_comb begin
      ind_next = act_pkg::DEACTIVATED_UP_IND;
      sel_next = act_pkg::TX_INFO0;
      trans_next = 1'b0;
      // outputs follow state_next and are registered, so nothing glitches at a strobe
      case (state_next)
         S_RESET: ind_next = nt_mode ? act_pkg::ERROR_IND : act_pkg::DEACTIVATED_UP_IND;
         S_DEACT: ind_next = act_pkg::DEACTIVATED_UP_IND;
         S_INFO1: ind_next = act_pkg::ACTIVATE_REQUEST_UP_IND;
         S_AWAKE: begin
            ind_next = nt_mode ? act_pkg::CLOCKS_REQUIRED_IND
                               : act_pkg::ACTIVATE_REQUEST_UP_IND;
         end
         S_PEND_ACT: begin
            sel_next = act_pkg::TX_INFO2;
            ind_next = rx_signal ? act_pkg::UPSTREAM_UNSYNC_IND : act_pkg::SIGNAL_LOST_IND;
         end
         S_SYNC: begin
            sel_next = act_pkg::TX_INFO2;
            ind_next = act_pkg::ACTIVATED_UP_IND;
         end
         S_ACTIVE: begin
            sel_next = act_pkg::TX_INFO4;
            trans_next = 1'b1;
            ind_next = act_pkg::ACTIVATED_UP_IND;
         end
         // the last indication stands until the deactivation completes
         S_PEND_DEACT: ind_next = ind_reg;
         S_UNACK: ind_next = act_pkg::DEACTIVATED_UP_IND;
         S_TEST: begin
            sel_next = single_sel ? act_pkg::TX_SINGLE : act_pkg::TX_CONT;
            ind_next = rx_signal ? act_pkg::UPSTREAM_UNSYNC_IND : act_pkg::SIGNAL_LOST_IND;
         end
         S_RESYNC: begin
            sel_next = act_pkg::TX_CONT;
            ind_next = ind_reg;
         end
         default: ind_next = act_pkg::DEACTIVATED_UP_IND;
      endcase
   end

   // =====================================================
   // state and timers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= S_RESET;
         timer_reg <= '0;
         loop_reg <= 1'b0;
         // reset shows the error code; in nt mode it stays until the acknowledge leaves the reset state
         ind_reg <= act_pkg::ERROR_IND;
         sel_reg <= act_pkg::TX_INFO0;
         trans_reg <= 1'b0;
         single_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         loop_reg <= loop_next;
         ind_reg <= ind_next;
         sel_reg <= sel_next;
         trans_reg <= trans_next;
         if (is_cont) single_reg <= 1'b0;
         else if (is_single) single_reg <= 1'b1;
      end
   end

   // info0 flywheel counts only while deactivation is pending
   // any gap in info0 restarts the flywheel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) info0_cnt_reg <= '0;
      else if (state_reg != S_PEND_DEACT || !rx_info0) info0_cnt_reg <= '0;
      else if (!info0_done) info0_cnt_reg <= info0_cnt_reg + 1'b1;
   end

   // =====================================================
   // test pulse generator: alternating marks at the selected rate
   // driven from the next selection so a mark never outlives its test mode
   // polarity is kept across mode changes so marks keep alternating on the line
   wire [TW-1:0] pulse_period = (sel_next == act_pkg::TX_SINGLE) ?
      TW'(SINGLE_CYC) : TW'(act_pkg::CONT_CYC);
   wire pulse_tick = pulse_cnt_reg >= pulse_period - 1'b1;
   wire pulsing = sel_next == act_pkg::TX_CONT || sel_next == act_pkg::TX_SINGLE;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_cnt_reg <= '0;
         pol_reg <= 1'b0;
         tx_pulse <= act_pkg::PULSE_NONE;
      end else if (!pulsing) begin
         pulse_cnt_reg <= '0;
         tx_pulse <= act_pkg::PULSE_NONE;
      end else if (pulse_tick) begin
         pulse_cnt_reg <= '0;
         pol_reg <= !pol_reg;
         tx_pulse <= pol_reg ? act_pkg::PULSE_NEG : act_pkg::PULSE_POS;
      end else begin
         pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
         tx_pulse <= act_pkg::PULSE_NONE;
      end
   end

   assign ind_code = ind_reg;
   assign tx_sel = act_pkg::tx_sel_t'(sel_reg);
   assign loop2_closed = loop_reg;
   assign transparent = trans_reg;
endmodule : network_side_activation_fsm

// File: sim/act_checker.sv
// Purpose: port-level checks of the activation fsm
// Assumes: one clock domain, async active-low reset
// Notes: bound to every fsm instance
`timescale 1ns/1ps
module act_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic nt_mode,
   input wire logic frame_strobe,
   input wire logic rx_info3,
   input wire logic rx_sync,
   input wire logic [3:0] ind_code,
   input wire act_pkg::tx_sel_t tx_sel,
   input wire logic [1:0] tx_pulse,
   input wire logic loop2_closed,
   input wire logic transparent
);
   // ==========================================
   // helper: last pulse polarity, forgotten on a mode change
   logic [1:0] last_pulse_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) last_pulse_reg <= 2'h0;
      else if ($changed(tx_sel)) last_pulse_reg <= 2'h0;
      else if (tx_pulse != 2'h0) last_pulse_reg <= tx_pulse;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   ind_legal_a: assert property (
      ind_code inside {4'h0, 4'h1, 4'h4, 4'h6, 4'h8, 4'hC, 4'hF}) else $error("bad indication");
   pulse_mode_a: assert property (tx_pulse != 2'h0 |->
      tx_sel inside {act_pkg::TX_CONT, act_pkg::TX_SINGLE}) else $error("pulse outside test");
   pulse_alt_a: assert property (
      tx_pulse != 2'h0 && last_pulse_reg != 2'h0 && $stable(tx_sel) |->
      tx_pulse != last_pulse_reg) else $error("pulse polarity repeated");
   info4_cause_a: assert property (
      $rose(tx_sel == act_pkg::TX_INFO4) && !nt_mode |-> $past(rx_info3))
      else $error("info4 without info3");
   info4_soon_a: assert property (!nt_mode && tx_sel == act_pkg::TX_INFO2 && rx_info3
      && rx_sync && !frame_strobe && !$past(frame_strobe) |=> tx_sel == act_pkg::TX_INFO4)
      else $error("info4 late");
   transp_info4_a: assert property (
      $rose(transparent) |-> tx_sel == act_pkg::TX_INFO4) else $error("transparent early");
   loop_sel_a: assert property (loop2_closed && nt_mode |->
      tx_sel inside {act_pkg::TX_INFO2, act_pkg::TX_INFO4}) else $error("loop with bad signal");
   deact_quiet_a: assert property (
      $rose(ind_code == 4'hF) && !nt_mode |-> tx_sel == act_pkg::TX_INFO0)
      else $error("deactivated but sending");
   error_nt_a: assert property (
      $rose(rst_n) && nt_mode |-> ind_code == 4'h6) else $error("no error after reset");
   line_wake_a: assert property (
      nt_mode && $rose(ind_code == 4'h8) |-> $past(ind_code) == 4'h0)
      else $error("info1 request without clocks-required");
   cover property (tx_sel == act_pkg::TX_INFO4 && transparent);
   cover property (tx_pulse == 2'h2);
   cover property (loop2_closed);
endmodule : act_checker
bind network_side_activation_fsm act_checker i_act_checker (.clk(clk), .rst_n(rst_n),
   .nt_mode(nt_mode), .frame_strobe(frame_strobe), .rx_info3(rx_info3), .rx_sync(rx_sync),
   .ind_code(ind_code), .tx_sel(tx_sel), .tx_pulse(tx_pulse), .loop2_closed(loop2_closed),
   .transparent(transparent));

// File: sim/ctrl_model.sv
// Purpose: upstream controller sending one command per 8-cycle frame
// Assumes: command request held by the bench
// Notes: a frame strobe every 8 cycles
`timescale 1ns/1ps
module ctrl_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] cmd_req,
   output logic frame_strobe,
   output logic [3:0] cmd_code
);
   logic [2:0] slot_reg;
   // code changes only at frame start so every strobe sees a whole frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_reg <= 3'h0;
         cmd_code <= act_pkg::DEACTIVATION_ACK_CMD;
      end else begin
         slot_reg <= slot_reg + 3'h1;
         if (slot_reg == 3'h0) cmd_code <= cmd_req;
      end
   end
   assign frame_strobe = (slot_reg == 3'h7);
endmodule : ctrl_model

// File: sim/network_side_activation_fsm_test.sv
// Purpose: self-checking bench for the activation fsm
// Assumes: shortened timers 50/40/80/20 cycles
// Notes: the controller model issues the commands
`timescale 1ns/1ps
module network_side_activation_fsm_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic nt_mode = 1'b0;
   logic rx_signal = 1'b0;
   logic rx_info0 = 1'b0;
   logic rx_info1 = 1'b0;
   logic rx_info3 = 1'b0;
   logic rx_sync = 1'b0;
   logic [3:0] cmd_req = act_pkg::DEACTIVATION_ACK_CMD;
   logic frame_strobe, loop2_closed, transparent;
   logic [3:0] cmd_code, ind_code;
   logic [1:0] tx_pulse, pa, pb;
   act_pkg::tx_sel_t tx_sel;
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   always #2 clk = ~clk;
   ctrl_model i_ctrl_model (.clk(clk), .rst_n(rst_n), .cmd_req(cmd_req),
      .frame_strobe(frame_strobe), .cmd_code(cmd_code));
   network_side_activation_fsm #(.AWAKE_CYC(50), .INFO0_CYC(40), .DEACT_CYC(80),
      .SINGLE_CYC(20)) i_network_side_activation_fsm (.clk(clk), .rst_n(rst_n),
      .nt_mode(nt_mode), .frame_strobe(frame_strobe), .cmd_code(cmd_code),
      .rx_signal(rx_signal), .rx_info0(rx_info0), .rx_info1(rx_info1), .rx_info3(rx_info3),
      .rx_sync(rx_sync), .ind_code(ind_code), .tx_sel(tx_sel), .tx_pulse(tx_pulse),
      .loop2_closed(loop2_closed), .transparent(transparent));
   // ==========================================
   // common tasks
   task end_of_test;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end
   task tick;
      @(posedge clk);
      #1;
   endtask : tick
   task check4(input logic [3:0] got, input logic [3:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check4
   task check_sel(input act_pkg::tx_sel_t got, input act_pkg::tx_sel_t exp);
      check4({1'b0, got}, {1'b0, exp});
   endtask : check_sel
   task check1(input logic got, input logic exp);
      check4({3'h0, got}, {3'h0, exp});
   endtask : check1
   task send(input logic [3:0] cmd);
      cmd_req = cmd;
      repeat (3) @(posedge frame_strobe);
      repeat (3) tick;
   endtask : send
   // bounded waits: the fsm gives no info3 timeout, the controller bounds it
   task wait_sel(input act_pkg::tx_sel_t exp, input int max);
      int n;
      for (n = 0; n < max && tx_sel !== exp; n++) tick;
      check_sel(tx_sel, exp);
   endtask : wait_sel
   task wait_ind(input logic [3:0] exp, input int max);
      int n;
      for (n = 0; n < max && ind_code !== exp; n++) tick;
      check4(ind_code, exp);
   endtask : wait_ind
   task grab(input int max);
      int n;
      pa = 2'h0;
      pb = 2'h0;
      for (n = 0; n < max && pb == 2'h0; n++) begin
         tick;
         if (tx_pulse != 2'h0 && pa == 2'h0) pa = tx_pulse;
         else if (tx_pulse != 2'h0) pb = tx_pulse;
      end
   endtask : grab
   // ==========================================
   // scenarios
   task t_reset(input logic nt);
      {rx_signal, rx_info0, rx_info1, rx_info3, rx_sync} = 5'h00;
      nt_mode = nt;
      cmd_req = act_pkg::DEACTIVATION_ACK_CMD;
      rst_n = 1'b0;
      repeat (5) tick;
      check4(ind_code, act_pkg::ERROR_IND);
      rst_n = 1'b1;
      repeat (2) tick;
      check4(ind_code, nt ? act_pkg::ERROR_IND : act_pkg::DEACTIVATED_UP_IND);
      check_sel(tx_sel, act_pkg::TX_INFO0);
      $display("test reset done");
   endtask : t_reset
   task t_lt_act;
      rx_signal = 1'b1;
      send(act_pkg::ACTIVATE_REQUEST_DOWN_CMD);
      check4(ind_code, act_pkg::ACTIVATE_REQUEST_UP_IND);
      repeat (40) tick;
      check_sel(tx_sel, act_pkg::TX_INFO0);
      wait_sel(act_pkg::TX_INFO2, 20);
      check4(ind_code, act_pkg::UPSTREAM_UNSYNC_IND);
      {rx_info3, rx_sync} = 2'h3;
      repeat (2) tick;
      check_sel(tx_sel, act_pkg::TX_INFO4);
      check4(ind_code, act_pkg::ACTIVATED_UP_IND);
      check1(transparent, 1'b1);
      send(act_pkg::RESYNC_DOWN_CMD);
      check_sel(tx_sel, act_pkg::TX_INFO4);
      {rx_info3, rx_sync} = 2'h0;
      repeat (2) tick;
      check_sel(tx_sel, act_pkg::TX_INFO2);
      {rx_info3, rx_sync} = 2'h3;
      repeat (2) tick;
      check_sel(tx_sel, act_pkg::TX_INFO4);
      $display("test lt activation done");
   endtask : t_lt_act
   task t_lt_deact;
      {rx_signal, rx_info3, rx_sync, rx_info0} = 4'h1;
      send(act_pkg::DEACTIVATE_REQUEST_CMD);
      check4(ind_code, act_pkg::SIGNAL_LOST_IND);
      wait_ind(act_pkg::DEACTIVATED_UP_IND, 50);
      check_sel(tx_sel, act_pkg::TX_INFO0);
      send(act_pkg::ACTIVATE_REQUEST_DOWN_CMD);
      repeat (70) tick;
      check_sel(tx_sel, act_pkg::TX_INFO0);
      check4(ind_code, act_pkg::DEACTIVATED_UP_IND);
      send(act_pkg::DEACTIVATION_ACK_CMD);
      send(act_pkg::ACTIVATE_REQUEST_DOWN_CMD);
      wait_sel(act_pkg::TX_INFO2, 70);
      $display("test lt deactivation done");
   endtask : t_lt_deact
   task t_pulses;
      send(act_pkg::CONTINUOUS_PULSE_CMD);
      check_sel(tx_sel, act_pkg::TX_CONT);
      grab(6000);
      check1(pb != 2'h0 && pa != pb, 1'b1);
      send(act_pkg::SINGLE_PULSE_CMD);
      check_sel(tx_sel, act_pkg::TX_SINGLE);
      grab(60);
      check1(pb != 2'h0 && pa != pb, 1'b1);
      send(act_pkg::DEACTIVATION_ACK_CMD);
      check4(ind_code, act_pkg::DEACTIVATED_UP_IND);
      $display("test pulses done");
   endtask : t_pulses
   task t_nt;
      wait_ind(act_pkg::DEACTIVATED_UP_IND, 30);
      rx_info1 = 1'b1;
      wait_ind(act_pkg::CLOCKS_REQUIRED_IND, 4);
      wait_ind(act_pkg::ACTIVATE_REQUEST_UP_IND, 60);
      send(act_pkg::ACTIVATE_REQUEST_DOWN_CMD);
      rx_info1 = 1'b0;
      wait_sel(act_pkg::TX_INFO2, 70);
      {rx_info3, rx_sync} = 2'h3;
      wait_ind(act_pkg::ACTIVATED_UP_IND, 4);
      check_sel(tx_sel, act_pkg::TX_INFO2);
      send(act_pkg::SWITCH_THROUGH_CMD);
      check_sel(tx_sel, act_pkg::TX_INFO4);
      check1(transparent, 1'b1);
      send(act_pkg::RESYNC_DOWN_CMD);
      check_sel(tx_sel, act_pkg::TX_CONT);
      send(act_pkg::LOOP_ACTIVATE_REQUEST_CMD);
      wait_sel(act_pkg::TX_INFO2, 70);
      check1(loop2_closed, 1'b1);
      send(act_pkg::SWITCH_THROUGH_LOOP_CMD);
      check_sel(tx_sel, act_pkg::TX_INFO4);
      check1(loop2_closed, 1'b1);
      send(act_pkg::DEACTIVATE_REQUEST_CMD);
      repeat (60) tick;
      check4(ind_code, act_pkg::ACTIVATED_UP_IND);
      wait_ind(act_pkg::DEACTIVATED_UP_IND, 30);
      check1(loop2_closed, 1'b0);
      $display("test nt done");
   endtask : t_nt
   initial begin
      t_reset(1'b0);
      t_lt_act();
      t_lt_deact();
      t_pulses();
      t_reset(1'b1);
      t_nt();
      end_of_test();
   end
endmodule : network_side_activation_fsm_test
